/* hdl/clip_sequencer.sv */
// What this block does
// - a byte parity error on read sets the parity check latch
// - the parity latch raises data check, which sets the read error latch
// - a space while read error is on steps the alternate clip triggers
// - first reread uses the lowered threshold to catch weak bits
// - second reread steps to the raised threshold to reject noise
// - third reread steps to the intermediate threshold
// - a read ending without data check clears both triggers at control end
// - with triggers cleared the next read uses the normal threshold
// - stepping continues on every further reread with no limit
// - writes use the raised threshold; a missed bit flags parity error
`timescale 1ns/1ps

module clip_sequencer
    import clip_pkg::*;
(
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // tape control pins
    input  wire logic        byte_parity_check,
    input  wire logic        space_op,
    input  wire logic        read_op,
    input  wire logic        write_op,
    input  wire logic        control_end_n,
    // clip level block
    output logic [1:0]       clip_state,
    output logic             write_clip,
    output logic             data_check,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        if (addr[7:2] == CTRL_OFFSET[7:2]) begin
            reg_index = 3'd1;
        end else if (addr[7:2] == STATUS_OFFSET[7:2]) begin
            reg_index = 3'd2;
        end else if (addr[7:2] == ATTEMPTS_OFFSET[7:2]) begin
            reg_index = 3'd3;
        end else if (addr[7:2] == LEVEL_OFFSET[7:2]) begin
            reg_index = 3'd4;
        end else begin
            reg_index = 3'd0;
        end
    endfunction : reg_index

    function automatic clip_state_type step_state(input clip_state_type s);
        case (s)
            CLIP_NORMAL: step_state = CLIP_ALT1;
            CLIP_ALT1:   step_state = CLIP_ALT2;
            CLIP_ALT2:   step_state = CLIP_ALT3;
            default:     step_state = CLIP_ALT1;
        endcase
    endfunction : step_state

    // ************************************************************
    // pin synchronisers and edges
    // ************************************************************
    logic [PIN_COUNT-1:0] pins_sync;
    logic                 space_prev_reg;
    logic                 end_prev_reg;

    clip_sync u_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .pins      ({control_end_n, write_op, read_op, space_op, byte_parity_check}),
        .pins_sync (pins_sync)
    );

    logic parity_s;
    logic space_rise;
    logic end_rise;
    logic start_fall;
    logic success;
    assign parity_s   = pins_sync[PIN_PARITY];
    assign space_rise = pins_sync[PIN_SPACE] & ~space_prev_reg;
    assign end_rise   = pins_sync[PIN_END_N] & ~end_prev_reg;
    assign start_fall = ~pins_sync[PIN_END_N] & end_prev_reg;

    // ************************************************************
    // core state
    // ************************************************************
    clip_state_type state_reg,    state_next;
    logic           parity_reg,   parity_next;
    logic           check_reg,    check_next;
    logic           rderr_reg,    rderr_next;
    logic           wclip_reg,    wclip_next;
    logic [11:0]    level_reg,    level_next;
    logic [15:0]    attempts_reg, attempts_next;
    logic           enable_reg;
    logic           clear_reg;

    assign success = end_rise & pins_sync[PIN_READ] & ~check_reg;

    always_comb begin
        parity_next = parity_reg;
        if (start_fall || clear_reg) begin
            parity_next = 1'b0;
        end
        if (parity_s) begin
            parity_next = 1'b1;
        end
        check_next = parity_reg;
        rderr_next = rderr_reg;
        if (success || clear_reg) begin
            rderr_next = 1'b0;
        end
        if (check_reg) begin
            rderr_next = 1'b1;
        end
        state_next    = state_reg;
        attempts_next = attempts_reg;
        if (!enable_reg || success || clear_reg) begin
            state_next    = CLIP_NORMAL;
            attempts_next = 16'h0000;
        end else if (space_rise && rderr_reg) begin
            state_next    = step_state(state_reg);
            attempts_next = attempts_reg + 16'h0001;
        end
        wclip_next = pins_sync[PIN_WRITE];
        if (wclip_reg) begin
            level_next = WRITE_MV;
        end else begin
            case (state_reg)
                CLIP_ALT1: level_next = ALT1_MV;
                CLIP_ALT2: level_next = ALT2_MV;
                CLIP_ALT3: level_next = ALT3_MV;
                default:   level_next = NORMAL_MV;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg      <= CLIP_NORMAL;
            parity_reg     <= 1'b0;
            check_reg      <= 1'b0;
            rderr_reg      <= 1'b0;
            wclip_reg      <= 1'b0;
            level_reg      <= NORMAL_MV;
            attempts_reg   <= 16'h0000;
            space_prev_reg <= 1'b0;
            end_prev_reg   <= 1'b1;
        end else if (ce) begin
            state_reg      <= state_next;
            parity_reg     <= parity_next;
            check_reg      <= check_next;
            rderr_reg      <= rderr_next;
            wclip_reg      <= wclip_next;
            level_reg      <= level_next;
            attempts_reg   <= attempts_next;
            space_prev_reg <= pins_sync[PIN_SPACE];
            end_prev_reg   <= pins_sync[PIN_END_N];
        end
    end

    assign clip_state = state_reg;
    assign write_clip = wclip_reg;
    assign data_check = check_reg;

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    logic        aw_got_reg,  aw_got_next;
    logic        w_got_reg,   w_got_next;
    logic [7:0]  waddr_reg,   waddr_next;
    logic [31:0] wdata_reg,   wdata_next;
    logic [3:0]  wstrb_reg,   wstrb_next;
    logic        awready_reg, awready_next;
    logic        wready_reg,  wready_next;
    logic        bvalid_reg,  bvalid_next;
    logic [1:0]  bresp_reg,   bresp_next;
    logic        arready_reg, arready_next;
    logic        rvalid_reg,  rvalid_next;
    logic [1:0]  rresp_reg,   rresp_next;
    logic [31:0] rdata_reg,   rdata_next;
    logic        enable_next;
    logic        clear_next;
    logic [2:0]  widx;
    logic [2:0]  ridx;

    assign widx = reg_index(waddr_reg);
    assign ridx = reg_index(araddr);

    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next  = w_got_reg;
        waddr_next  = waddr_reg;
        wdata_next  = wdata_reg;
        wstrb_next  = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        enable_next = enable_reg;
        clear_next  = 1'b0;
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (awvalid && awready_reg) begin
            aw_got_next = 1'b1;
            waddr_next  = awaddr;
        end
        if (wvalid && wready_reg) begin
            w_got_next = 1'b1;
            wdata_next = wdata;
            wstrb_next = wstrb;
        end
        if (aw_got_reg && w_got_reg && !bvalid_reg) begin
            aw_got_next = 1'b0;
            w_got_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = (widx == 3'd0) ? RESP_SLVERR : RESP_OKAY;
            if (widx == 3'd1 && wstrb_reg[0]) begin
                enable_next = wdata_reg[CTRL_ENABLE_BIT];
                clear_next  = wdata_reg[CTRL_CLEAR_BIT];
            end
        end
        awready_next = !aw_got_next && !bvalid_next;
        wready_next  = !w_got_next && !bvalid_next;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            if (ridx == 3'd1) begin
                rdata_next[CTRL_ENABLE_BIT] = enable_reg;
            end else if (ridx == 3'd2) begin
                rdata_next[STAT_PARITY_BIT] = parity_reg;
                rdata_next[STAT_CHECK_BIT]  = check_reg;
                rdata_next[STAT_RDERR_BIT]  = rderr_reg;
                rdata_next[STAT_STATE_LSB +: 2] = state_reg;
                rdata_next[STAT_WRITE_BIT]  = wclip_reg;
            end else if (ridx == 3'd3) begin
                rdata_next[15:0] = attempts_reg;
            end else if (ridx == 3'd4) begin
                rdata_next[11:0] = level_reg;
            end else begin
                rresp_next = RESP_SLVERR;
            end
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            waddr_reg   <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
            enable_reg  <= CTRL_ENABLE_RESET;
            clear_reg   <= 1'b0;
        end else if (ce) begin
            aw_got_reg  <= aw_got_next;
            w_got_reg   <= w_got_next;
            waddr_reg   <= waddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
            enable_reg  <= enable_next;
            clear_reg   <= clear_next;
        end
    end

    assign awready = awready_reg;
    assign wready  = wready_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = arready_reg;
    assign rvalid  = rvalid_reg;
    assign rresp   = rresp_reg;
    assign rdata   = rdata_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    logic step_ok;
    assign step_ok = ce && enable_reg && !success && !clear_reg && space_rise && rderr_reg;

    parity_latch_a : assert property (
        @(posedge aclk) disable iff (!aresetn) ce && parity_s |=> parity_reg)
        else $error("parity latch not set");

    check_chain_a : assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && parity_reg |=> check_reg)
        else $error("data check not raised");

    read_error_a : assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && check_reg |=> rderr_reg)
        else $error("read error not set");

    first_step_a : assert property (
        @(posedge aclk) disable iff (!aresetn)
        step_ok && state_reg == CLIP_NORMAL |=> state_reg == CLIP_ALT1)
        else $error("first reread not lowered");

    second_step_a : assert property (
        @(posedge aclk) disable iff (!aresetn)
        step_ok && state_reg == CLIP_ALT1 |=> state_reg == CLIP_ALT2)
        else $error("second reread not raised");

    third_step_a : assert property (
        @(posedge aclk) disable iff (!aresetn)
        step_ok && state_reg == CLIP_ALT2 |=> state_reg == CLIP_ALT3)
        else $error("third reread not intermediate");

    wrap_step_a : assert property (
        @(posedge aclk) disable iff (!aresetn)
        step_ok && state_reg == CLIP_ALT3 |=> state_reg == CLIP_ALT1
        && attempts_reg == $past(attempts_reg) + 16'h0001)
        else $error("stepping did not wrap");

    clean_clear_a : assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && success && !check_reg |=> state_reg == CLIP_NORMAL && !rderr_reg)
        else $error("clean read did not clear");

    normal_level_a : assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && state_reg == CLIP_NORMAL && !wclip_reg |=> level_reg == NORMAL_MV)
        else $error("normal level wrong");

    write_level_a : assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && pins_sync[PIN_WRITE] ##1 ce |=> level_reg == WRITE_MV)
        else $error("write level not raised");

endmodule : clip_sequencer

/* hdl/clip_pkg.sv */
package clip_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
    localparam logic [7:0]  ATTEMPTS_OFFSET = 8'h08;
    localparam logic [7:0]  LEVEL_OFFSET    = 8'h0c;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_ENABLE_BIT   = 0;
    localparam int CTRL_CLEAR_BIT    = 1;
    localparam int STAT_PARITY_BIT   = 0;
    localparam int STAT_CHECK_BIT    = 1;
    localparam int STAT_RDERR_BIT    = 2;
    localparam int STAT_STATE_LSB    = 3;
    localparam int STAT_WRITE_BIT    = 5;

    // ************************************************************
    // reset values and bus answers
    // ************************************************************
    localparam logic       CTRL_ENABLE_RESET = 1'b1;
    localparam logic [1:0] RESP_OKAY         = 2'b00;
    localparam logic [1:0] RESP_SLVERR       = 2'b10;

    // ************************************************************
    // pin bundle width and bit positions
    // ************************************************************
    localparam int         PIN_COUNT   = 5;
    localparam int         PIN_PARITY  = 0;
    localparam int         PIN_SPACE   = 1;
    localparam int         PIN_READ    = 2;
    localparam int         PIN_WRITE   = 3;
    localparam int         PIN_END_N   = 4;
    localparam logic [4:0] PIN_RESET   = 5'h10;

    // ************************************************************
    // clipping thresholds in millivolts
    // ************************************************************
    localparam logic [11:0] NORMAL_MV = 12'd800;
    localparam logic [11:0] ALT1_MV   = 12'd400;
    localparam logic [11:0] ALT2_MV   = 12'd1100;
    localparam logic [11:0] ALT3_MV   = 12'd600;
    localparam logic [11:0] WRITE_MV  = 12'd1100;

    // ************************************************************
    // threshold choice, gray coded along the stepping order except the wrap from alt3 back to alt1
    // ************************************************************
    typedef enum logic [1:0] {
        CLIP_NORMAL = 2'b00,
        CLIP_ALT1   = 2'b01,
        CLIP_ALT2   = 2'b11,
        CLIP_ALT3   = 2'b10
    } clip_state_type;

endpackage : clip_pkg

/* hdl/clip_sync.sv */
`timescale 1ns/1ps

module clip_sync
    import clip_pkg::*;
(
    // clock, reset, enable
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 ce,
    // pins in, synchronised out
    input  wire logic [PIN_COUNT-1:0] pins,
    output logic      [PIN_COUNT-1:0] pins_sync
);

    logic [PIN_COUNT-1:0] stage1_reg;
    logic [PIN_COUNT-1:0] stage2_reg;

    // ************************************************************
    // two flip-flops per pin
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    stage1_reg[i] <= PIN_RESET[i];
                    stage2_reg[i] <= PIN_RESET[i];
                end else if (ce) begin
                    stage1_reg[i] <= pins[i];
                    stage2_reg[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate

    assign pins_sync = stage2_reg;

endmodule : clip_sync

/* bench/tape_model.sv */
`timescale 1ns/1ps

// ************************************************************
// tape motion control model
// ************************************************************
module tape_model (
    // clock
    input  wire logic aclk,
    // tape control pins
    output logic      byte_parity_check,
    output logic      space_op,
    output logic      read_op,
    output logic      write_op,
    output logic      control_end_n
);
    initial begin
        byte_parity_check = 1'b0;
        space_op = 1'b0;
        read_op = 1'b0;
        write_op = 1'b0;
        control_end_n = 1'b1;
    end

    task automatic wait_edges(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_edges

    task automatic space_over();
        control_end_n <= 1'b0;
        space_op <= 1'b1;
        wait_edges(4);
        space_op <= 1'b0;
        wait_edges(2);
        control_end_n <= 1'b1;
        wait_edges(8);
    endtask : space_over

    // starts a read or write, optionally with a parity fault
    task automatic op_begin(input logic wr, input logic bad);
        control_end_n <= 1'b0;
        read_op <= !wr;
        write_op <= wr;
        wait_edges(3);
        byte_parity_check <= bad;
        wait_edges(2);
        byte_parity_check <= 1'b0;
        wait_edges(8);
    endtask : op_begin

    // control end rises while the operation line is still up
    task automatic op_end();
        control_end_n <= 1'b1;
        wait_edges(4);
        read_op <= 1'b0;
        write_op <= 1'b0;
        wait_edges(6);
    endtask : op_end

    task automatic read_block(input logic bad);
        op_begin(1'b0, bad);
        op_end();
    endtask : read_block
endmodule : tape_model

/* bench/alternate_clip_level_sequencer_bench.sv */
`timescale 1ns/1ps

module alternate_clip_level_sequencer_bench import clip_pkg::*;;
    logic        aclk, aresetn, ce;
    logic        byte_parity_check, space_op, read_op, write_op, control_end_n;
    logic [1:0]  clip_state, prev_state, bresp, rresp;
    logic        write_clip, data_check;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [33:0] bus_q[$];
    logic [1:0]  st_q[$];
    int          n_errors, n_checks, cyc, i, n_steps;
    clip_state_type step_tab[3] = '{CLIP_ALT1, CLIP_ALT2, CLIP_ALT3};
    logic [11:0]    mv_tab[3] = '{ALT1_MV, ALT2_MV, ALT3_MV};

    clip_sequencer dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .byte_parity_check(byte_parity_check), .space_op(space_op), .read_op(read_op),
        .write_op(write_op), .control_end_n(control_end_n), .clip_state(clip_state),
        .write_clip(write_clip), .data_check(data_check), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    tape_model tm_u (.aclk(aclk), .byte_parity_check(byte_parity_check),
        .space_op(space_op), .read_op(read_op), .write_op(write_op),
        .control_end_n(control_end_n));

    // ************************************************************
    // checking helpers
    // ************************************************************
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [33:0] pop_bus();
        if (bus_q.size() == 0) return 'x;
        return bus_q.pop_front();
    endfunction : pop_bus

    function automatic logic [33:0] pop_st();
        if (st_q.size() == 0) return 'x;
        return {32'h0, st_q.pop_front()};
    endfunction : pop_st

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // ************************************************************
    // axi4-lite master
    // ************************************************************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] r);
        bus_q.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bus_q.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    // ************************************************************
    // clock, monitor, timeout
    // ************************************************************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            end_sim();
        end else if (!aresetn) begin
            prev_state <= clip_state;
        end else begin
            if (bvalid && bready) check({bresp, 32'h0}, pop_bus());
            if (rvalid && rready) check({rresp, rdata}, pop_bus());
            if (clip_state !== prev_state) check({32'h0, clip_state}, pop_st());
            prev_state <= clip_state;
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        seed = 32'h91bc7b04;
        cyc = 0;
        aresetn = 1'b0;
        ce = 1'b1;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_read(CTRL_OFFSET, 32'h1, RESP_OKAY);
        axi_read(STATUS_OFFSET, 32'h0, RESP_OKAY);
        axi_read(LEVEL_OFFSET, {20'h0, NORMAL_MV}, RESP_OKAY);
        axi_read(8'h10, 32'h0, RESP_SLVERR);
        axi_write(8'h10, $random(seed), 4'hf, RESP_SLVERR);
        axi_write(STATUS_OFFSET, $random(seed), 4'hf, RESP_OKAY);
        $display("test reset and map done");
        tm_u.space_over();
        tm_u.read_block(1'b1);
        axi_read(STATUS_OFFSET, 32'h7, RESP_OKAY);
        check({33'h0, data_check}, 34'h1);
        n_steps = 4 + ($random(seed) & 3);
        for (i = 0; i < n_steps; i++) begin
            st_q.push_back(step_tab[i % 3]);
            tm_u.space_over();
            axi_read(LEVEL_OFFSET, {20'h0, mv_tab[i % 3]}, RESP_OKAY);
            tm_u.read_block(1'b1);
        end
        axi_read(ATTEMPTS_OFFSET, 32'(n_steps), RESP_OKAY);
        axi_read(STATUS_OFFSET, {27'h0, step_tab[(n_steps-1)%3], 3'h7}, RESP_OKAY);
        st_q.push_back(step_tab[n_steps % 3]);
        st_q.push_back(CLIP_NORMAL);
        tm_u.space_over();
        tm_u.read_block(1'b0);
        axi_read(LEVEL_OFFSET, {20'h0, NORMAL_MV}, RESP_OKAY);
        axi_read(ATTEMPTS_OFFSET, 32'h0, RESP_OKAY);
        check({33'h0, data_check}, 34'h0);
        $display("test reread stepping done");
        tm_u.op_begin(1'b1, 1'b1);
        axi_read(STATUS_OFFSET, 32'h27, RESP_OKAY);
        axi_read(LEVEL_OFFSET, {20'h0, WRITE_MV}, RESP_OKAY);
        check({33'h0, write_clip}, 34'h1);
        tm_u.op_end();
        ce <= 1'b0;
        tm_u.space_over();
        ce <= 1'b1;
        axi_read(STATUS_OFFSET, 32'h7, RESP_OKAY);
        axi_write(CTRL_OFFSET, 32'h3, 4'hf, RESP_OKAY);
        axi_read(STATUS_OFFSET, 32'h4, RESP_OKAY);
        $display("test write check done");
        axi_write(CTRL_OFFSET, 32'h0, 4'he, RESP_OKAY);
        axi_read(CTRL_OFFSET, 32'h1, RESP_OKAY);
        axi_write(CTRL_OFFSET, 32'h0, 4'hf, RESP_OKAY);
        tm_u.read_block(1'b1);
        tm_u.space_over();
        axi_read(ATTEMPTS_OFFSET, 32'h0, RESP_OKAY);
        axi_write(CTRL_OFFSET, 32'h3, 4'hf, RESP_OKAY);
        axi_read(STATUS_OFFSET, 32'h0, RESP_OKAY);
        $display("test enable and clear done");
        check(st_q.size() + bus_q.size(), 34'h0);
        end_sim();
    end
endmodule : alternate_clip_level_sequencer_bench
